// ### rtl/dsa_pkg.sv
// Constants and types shared by the data-space access unit
package dsa_pkg;

  localparam int DSA_EA_W      = 16;
  localparam int DSA_DATA_W    = 16;
  localparam int DSA_PAGE_W    = 8;
  localparam int DSA_LOW_W     = 15;
  localparam int DSA_PROG_W    = 24;
  localparam int DSA_PADDR_W   = DSA_PAGE_W + DSA_LOW_W;

  // Fixed data-space map
  localparam logic [15:0] DSA_RAM_LO = 16'h0800;
  localparam logic [15:0] DSA_Y_LO   = 16'h0C00;
  localparam logic [15:0] DSA_Y_HI   = 16'h0FFF;

  // Prefetch pointer register numbers
  localparam logic [3:0] DSA_X_PTR_A = 4'h8;
  localparam logic [3:0] DSA_X_PTR_B = 4'h9;
  localparam logic [3:0] DSA_Y_PTR_A = 4'hA;
  localparam logic [3:0] DSA_Y_PTR_B = 4'hB;

  // Program-space view penalties in cycles
  localparam logic [1:0] DSA_EXTRA_NONE  = 2'h0;
  localparam logic [1:0] DSA_EXTRA_SHORT = 2'h1;
  localparam logic [1:0] DSA_EXTRA_LONG  = 2'h2;

  // Pointer steps
  localparam logic [15:0] DSA_STEP_BYTE = 16'h0001;
  localparam logic [15:0] DSA_STEP_WORD = 16'h0002;

  // Reset values
  localparam logic [15:0] DSA_ZERO_WORD = 16'h0000;
  localparam logic [22:0] DSA_ZERO_PADDR = 23'h000000;
  localparam logic [14:0] DSA_ZERO_WADDR = 15'h0000;

  typedef enum logic [1:0] {
    CLS_MAC_PREFETCH,
    CLS_MOVE,
    CLS_DOUBLE_MOVE,
    CLS_OTHER
  } dsa_class_t;

endpackage

// ### rtl/dsa_psv_penalty.sv
// Extra cycles taken by a program-space view access
`timescale 1ns/10ps
module dsa_psv_penalty
  import dsa_pkg::*;
(
  input  wire logic       psvHit,
  input  wire dsa_class_t instClass,
  input  wire logic       inLoop,
  input  wire logic       loopFirst,
  input  wire logic       loopLast,
  input  wire logic       loopIntExit,
  input  wire logic       loopReentry,
  output logic [1:0]      extraCycles
);

  always_comb
  begin
    extraCycles = DSA_EXTRA_NONE;
    if (psvHit)
    begin
      if (inLoop)
      begin
        // Edge iterations pay two, middle ones run single cycle
        if (loopFirst || loopLast || loopIntExit || loopReentry)
        begin
          extraCycles = DSA_EXTRA_LONG;
        end
      end
      else if (instClass == CLS_OTHER)
      begin
        extraCycles = DSA_EXTRA_LONG;
      end
      else
      begin
        extraCycles = DSA_EXTRA_SHORT;
      end
    end
  end

endmodule

// ### rtl/dsa_ptr_update.sv
// Pointer post-modify with modulo and bit-reversed stepping
`timescale 1ns/10ps
module dsa_ptr_update
  import dsa_pkg::*;
(
  input  wire logic [15:0] ptrIn,
  input  wire logic        byteOp,
  input  wire logic        modEnable,
  input  wire logic [15:0] modStart,
  input  wire logic [15:0] modEnd,
  input  wire logic        bitRevEnable,
  input  wire logic [15:0] bitRevStep,
  input  wire logic        xWrite,
  output logic [15:0]      ptrNext
);

  function automatic logic [15:0] revBits(input logic [15:0] v);
    logic [15:0] r;
    r = DSA_ZERO_WORD;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  always_comb
  begin
    ptrNext = ptrIn + (byteOp ? DSA_STEP_BYTE : DSA_STEP_WORD);
    if (bitRevEnable && xWrite && !byteOp)
    begin
      ptrNext = revBits(revBits(ptrIn) + revBits(bitRevStep));
    end
    else if (modEnable && ptrIn[15:1] == modEnd[15:1])
    begin
      ptrNext = modStart;
    end
  end

endmodule

// ### rtl/dsa_top.sv
// Data-space access unit: decode, lane steering, program view, traps
// What this block does
// - Top address bit plus enable reads program memory
// - Program address is page then low fifteen bits
// - Program view returns low sixteen word bits
// - Table operations bypass program view mapping
// - Outside loops add one or two cycles
// - Loop edge iterations add two cycles
// - Separate X read and write; X writes only
// - Modulo both spaces; bit-reverse only X writes
// - Prefetch pointers fixed to X or Y
// - No Y writes; writeback uses X bus
// - Unimplemented or foreign reads return zero
// - Crossed prefetch pointer returns zero
// - Sixteen bit byte addresses, word organised
// - X/Y boundary fixed in hardware
// - Byte read selects byte onto low lane
// - Byte write strobes only its lane
// - Y path fetches words only
// - Pointer step one for bytes, two words
// - Misaligned word traps; write store suppressed
`timescale 1ns/10ps
module dsa_top
  import dsa_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              programSpaceViewEnable,
  input  wire logic [7:0]        programViewPage,
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire logic              reqWrite,
  input  wire logic              reqByte,
  input  wire logic              reqMac,
  input  wire logic              reqAccWriteback,
  input  wire logic              reqTable,
  input  wire dsa_class_t        reqClass,
  input  wire logic [15:0]       reqAddr,
  input  wire logic [15:0]       reqWdata,
  input  wire logic [3:0]        reqXPtr,
  input  wire logic [15:0]       reqYAddr,
  input  wire logic [3:0]        reqYPtr,
  input  wire logic              inLoop,
  input  wire logic              loopFirst,
  input  wire logic              loopLast,
  input  wire logic              loopIntExit,
  input  wire logic              loopReentry,
  output logic                   rspValid,
  output logic [15:0]            rspXData,
  output logic [15:0]            rspYData,
  output logic                   addrErrTrap,
  output logic [14:0]            xRamAddr,
  output logic                   xRamRd,
  output logic                   xRamWr,
  output logic [1:0]             xRamBe,
  output logic [15:0]            xRamWdata,
  input  wire logic [15:0]       xRamRdata,
  output logic [14:0]            yRamAddr,
  output logic                   yRamRd,
  input  wire logic [15:0]       yRamRdata,
  output logic [22:0]            progAddr,
  output logic                   progRd,
  input  wire logic [23:0]       progRdata,
  input  wire logic              ptrValid,
  input  wire logic [15:0]       ptrIn,
  input  wire logic              ptrByte,
  input  wire logic              ptrModEnable,
  input  wire logic [15:0]       ptrModStart,
  input  wire logic [15:0]       ptrModEnd,
  input  wire logic              ptrBitRevEnable,
  input  wire logic [15:0]       ptrBitRevStep,
  input  wire logic              ptrXWrite,
  output logic                   ptrOutValid,
  output logic [15:0]            ptrOut
);

  typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_CAPT, ST_PAD} dsa_state_t;
  typedef enum logic [1:0] {SRC_ZERO, SRC_RAM, SRC_PROG} dsa_src_t;

  dsa_state_t  state_reg;
  dsa_src_t    xSrc_reg;
  logic        opWrite_reg;
  logic        opByte_reg;
  logic        opHigh_reg;
  logic        opMac_reg;
  logic        yOk_reg;
  logic        trap_reg;
  logic [1:0]  extra_reg;
  logic [1:0]  padCnt_reg;
  logic        rspValid_reg;
  logic        addrErrTrap_reg;
  logic [15:0] rspXData_reg;
  logic [15:0] rspYData_reg;
  logic [14:0] xRamAddr_reg;
  logic        xRamRd_reg;
  logic        xRamWr_reg;
  logic [1:0]  xRamBe_reg;
  logic [15:0] xRamWdata_reg;
  logic [14:0] yRamAddr_reg;
  logic        yRamRd_reg;
  logic [22:0] progAddr_reg;
  logic        progRd_reg;
  logic        ptrOutValid_reg;
  logic [15:0] ptr_next;
  logic [15:0] ptrOut_reg;

  logic        take;
  logic        isWrite;
  logic        psvSel;
  logic        xOk;
  logic        yOk;
  logic        misaligned;
  logic        storeOk;
  logic [1:0]  extraCycles;
  logic        finish;

  // Address decode over the fixed map
  function automatic logic inRam(input logic [15:0] a);
    return (a >= DSA_RAM_LO) && (a <= DSA_Y_HI);
  endfunction

  function automatic logic inY(input logic [15:0] a);
    return (a >= DSA_Y_LO) && (a <= DSA_Y_HI);
  endfunction

  function automatic logic isXPtr(input logic [3:0] p);
    return (p == DSA_X_PTR_A) || (p == DSA_X_PTR_B);
  endfunction

  function automatic logic isYPtr(input logic [3:0] p);
    return (p == DSA_Y_PTR_A) || (p == DSA_Y_PTR_B);
  endfunction

  function automatic logic [1:0] laneEnable(input logic isByte, input logic a0);
    return isByte ? (a0 ? 2'h2 : 2'h1) : 2'h3;
  endfunction

  function automatic logic [15:0] pickByte(input logic isByte, input logic hi,
                                           input logic [15:0] w);
    return isByte ? {8'h00, (hi ? w[15:8] : w[7:0])} : w;
  endfunction

  assign reqReady = (state_reg == ST_IDLE);
  assign take     = reqValid && reqReady;

  // Request decode
  always_comb
  begin
    isWrite    = (reqWrite || reqAccWriteback) && !reqMac;
    psvSel     = programSpaceViewEnable && reqAddr[15] && !reqTable;
    misaligned = (!reqByte || reqMac) && (reqAddr[0] || (reqMac && reqYAddr[0]));
    if (reqMac)
    begin
      // Prefetch X pointers may not reach Y space and vice versa
      xOk = isXPtr(reqXPtr) && (psvSel || (inRam(reqAddr) && !inY(reqAddr)));
      yOk = isYPtr(reqYPtr) && inY(reqYAddr);
    end
    else
    begin
      xOk = psvSel || inRam(reqAddr);
      yOk = 1'b0;
    end
    // Writes, writeback included, use the X bus over the combined space
    storeOk = isWrite && !psvSel && inRam(reqAddr) && !misaligned;
  end

  dsa_psv_penalty u_penalty (
    .psvHit      (psvSel && xOk && !isWrite),
    .instClass   (reqClass),
    .inLoop      (inLoop),
    .loopFirst   (loopFirst),
    .loopLast    (loopLast),
    .loopIntExit (loopIntExit),
    .loopReentry (loopReentry),
    .extraCycles (extraCycles)
  );

  // Sequencer
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg  <= ST_IDLE;
      padCnt_reg <= 2'h0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (take)
          begin
            state_reg <= ST_MEM;
          end
        end
        ST_MEM:
        begin
          state_reg <= ST_CAPT;
        end
        ST_CAPT:
        begin
          padCnt_reg <= extra_reg;
          state_reg  <= (extra_reg == DSA_EXTRA_NONE) ? ST_IDLE : ST_PAD;
        end
        ST_PAD:
        begin
          padCnt_reg <= padCnt_reg - 2'h1;
          if (padCnt_reg == 2'h1)
          begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign finish = ((state_reg == ST_CAPT) && (extra_reg == DSA_EXTRA_NONE)) ||
                  ((state_reg == ST_PAD) && (padCnt_reg == 2'h1));

  // Latched request attributes
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      xSrc_reg    <= SRC_ZERO;
      opWrite_reg <= 1'b0;
      opByte_reg  <= 1'b0;
      opHigh_reg  <= 1'b0;
      opMac_reg   <= 1'b0;
      yOk_reg     <= 1'b0;
      trap_reg    <= 1'b0;
      extra_reg   <= DSA_EXTRA_NONE;
    end
    else if (take)
    begin
      xSrc_reg    <= !xOk ? SRC_ZERO : (psvSel ? SRC_PROG : SRC_RAM);
      opWrite_reg <= isWrite;
      opByte_reg  <= reqByte && !reqMac;
      opHigh_reg  <= reqAddr[0];
      opMac_reg   <= reqMac;
      yOk_reg     <= yOk;
      trap_reg    <= misaligned;
      extra_reg   <= extraCycles;
    end
  end

  // Memory strobes, asserted for the one cycle after the request is taken
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      xRamAddr_reg  <= DSA_ZERO_WADDR;
      xRamRd_reg    <= 1'b0;
      xRamWr_reg    <= 1'b0;
      xRamBe_reg    <= 2'h0;
      xRamWdata_reg <= DSA_ZERO_WORD;
      yRamAddr_reg  <= DSA_ZERO_WADDR;
      yRamRd_reg    <= 1'b0;
      progAddr_reg  <= DSA_ZERO_PADDR;
      progRd_reg    <= 1'b0;
    end
    else if (take)
    begin
      xRamAddr_reg  <= reqAddr[15:1];
      xRamRd_reg    <= !isWrite && xOk && !psvSel;
      progRd_reg    <= !isWrite && xOk && psvSel;
      progAddr_reg  <= {programViewPage, reqAddr[14:0]};
      xRamWr_reg    <= storeOk;
      xRamBe_reg    <= storeOk ? laneEnable(reqByte, reqAddr[0]) : 2'h0;
      xRamWdata_reg <= reqByte ? {reqWdata[7:0], reqWdata[7:0]} : reqWdata;
      yRamAddr_reg  <= reqYAddr[15:1];
      yRamRd_reg    <= yOk;
    end
    else
    begin
      xRamRd_reg <= 1'b0;
      xRamWr_reg <= 1'b0;
      xRamBe_reg <= 2'h0;
      yRamRd_reg <= 1'b0;
      progRd_reg <= 1'b0;
    end
  end

  // Returned data capture
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rspXData_reg <= DSA_ZERO_WORD;
      rspYData_reg <= DSA_ZERO_WORD;
    end
    else if (state_reg == ST_CAPT)
    begin
      unique case (xSrc_reg)
        SRC_RAM:  rspXData_reg <= opWrite_reg ? DSA_ZERO_WORD :
                                  pickByte(opByte_reg, opHigh_reg, xRamRdata);
        SRC_PROG: rspXData_reg <= opWrite_reg ? DSA_ZERO_WORD :
                                  pickByte(opByte_reg, opHigh_reg, progRdata[15:0]);
        default:  rspXData_reg <= DSA_ZERO_WORD;
      endcase
      rspYData_reg <= yOk_reg ? yRamRdata : DSA_ZERO_WORD;
    end
  end

  // Completion and trap pulses
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rspValid_reg    <= 1'b0;
      addrErrTrap_reg <= 1'b0;
    end
    else
    begin
      rspValid_reg    <= finish;
      addrErrTrap_reg <= finish && trap_reg;
    end
  end

  // Pointer post-modification
  dsa_ptr_update u_ptr (
    .ptrIn        (ptrIn),
    .byteOp       (ptrByte),
    .modEnable    (ptrModEnable),
    .modStart     (ptrModStart),
    .modEnd       (ptrModEnd),
    .bitRevEnable (ptrBitRevEnable),
    .bitRevStep   (ptrBitRevStep),
    .xWrite       (ptrXWrite),
    .ptrNext      (ptr_next)
  );

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ptrOut_reg      <= DSA_ZERO_WORD;
      ptrOutValid_reg <= 1'b0;
    end
    else
    begin
      ptrOutValid_reg <= ptrValid;
      if (ptrValid)
      begin
        ptrOut_reg <= ptr_next;
      end
    end
  end

  assign rspValid    = rspValid_reg;
  assign addrErrTrap = addrErrTrap_reg;
  assign rspXData    = rspXData_reg;
  assign rspYData    = rspYData_reg;
  assign xRamAddr    = xRamAddr_reg;
  assign xRamRd      = xRamRd_reg;
  assign xRamWr      = xRamWr_reg;
  assign xRamBe      = xRamBe_reg;
  assign xRamWdata   = xRamWdata_reg;
  assign yRamAddr    = yRamAddr_reg;
  assign yRamRd      = yRamRd_reg;
  assign progAddr    = progAddr_reg;
  assign progRd      = progRd_reg;
  assign ptrOut      = ptrOut_reg;
  assign ptrOutValid = ptrOutValid_reg;

  // Checks
  a_psv_route: assert property (@(posedge sys_clk) disable iff (!reset_n)
    take && !isWrite && xOk && psvSel |=> progRd && !xRamRd)
    else $error("program view read not sent to program memory");

  a_psv_page: assert property (@(posedge sys_clk) disable iff (!reset_n)
    take && psvSel |=> progAddr == {$past(programViewPage), $past(reqAddr[14:0])})
    else $error("program view address wrong");

  a_table_bypass: assert property (@(posedge sys_clk) disable iff (!reset_n)
    take && reqTable |=> !progRd)
    else $error("table operation used program view");

  a_short_penalty: assert property (@(posedge sys_clk) disable iff (!reset_n)
    take && !isWrite && xOk && psvSel && !inLoop && reqClass == CLS_MOVE
    |-> ##4 rspValid)
    else $error("one-cycle penalty not applied");

  a_long_penalty: assert property (@(posedge sys_clk) disable iff (!reset_n)
    take && !isWrite && xOk && psvSel && !inLoop && reqClass == CLS_OTHER
    |=> !rspValid [*4] ##1 rspValid)
    else $error("two-cycle penalty not applied");

  a_loop_middle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    take && inLoop && !loopFirst && !loopLast && !loopIntExit && !loopReentry
    |-> ##3 rspValid)
    else $error("middle loop iteration was slowed");

  a_zero_invalid: assert property (@(posedge sys_clk) disable iff (!reset_n)
    take && !xOk |-> ##3 rspValid && rspXData == DSA_ZERO_WORD)
    else $error("invalid access returned data");

  a_cross_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rspValid && opMac_reg && !yOk_reg |-> rspYData == DSA_ZERO_WORD)
    else $error("crossed prefetch returned data");

  a_byte_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rspValid && opByte_reg |-> rspXData[15:8] == 8'h00)
    else $error("byte read leaked high lane");

  a_byte_lane: assert property (@(posedge sys_clk) disable iff (!reset_n)
    take && storeOk && reqByte |=> xRamWr && xRamBe[$past(reqAddr[0])] && $onehot(xRamBe))
    else $error("byte write strobed wrong lane");

  a_trap_store: assert property (@(posedge sys_clk) disable iff (!reset_n)
    take && isWrite && misaligned |=> !xRamWr ##2 addrErrTrap)
    else $error("misaligned write stored or not trapped");

  a_ptr_step: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ptrValid && !ptrModEnable && !ptrBitRevEnable
    |=> ptrOut == $past(ptrIn) + ($past(ptrByte) ? DSA_STEP_BYTE : DSA_STEP_WORD))
    else $error("pointer step not scaled by size");

endmodule

// ### dv/dsa_mem_model.sv
// Data RAM and program memory model facing the access unit
`timescale 1ns/10ps
module dsa_mem_model
  import dsa_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [14:0] xRamAddr,
  input  wire logic        xRamRd,
  input  wire logic        xRamWr,
  input  wire logic [1:0]  xRamBe,
  input  wire logic [15:0] xRamWdata,
  output logic      [15:0] xRamRdata,
  input  wire logic [14:0] yRamAddr,
  input  wire logic        yRamRd,
  output logic      [15:0] yRamRdata,
  input  wire logic [22:0] progAddr,
  input  wire logic        progRd,
  output logic      [23:0] progRdata
);
  logic [15:0] mem [0:32767];

  initial
  begin
    for (int i = 0; i < 32768; i++)
      mem[i] = 16'hA500 ^ 16'(i);
    xRamRdata = 16'h0000;
    yRamRdata = 16'h0000;
    progRdata = 24'h000000;
  end

  // Each byte lane has its own write line
  always @(posedge sys_clk)
  begin
    if (xRamWr && xRamBe[0])
      mem[xRamAddr][7:0] <= xRamWdata[7:0];
    if (xRamWr && xRamBe[1])
      mem[xRamAddr][15:8] <= xRamWdata[15:8];
  end

  // Data valid the cycle after the strobe, toggling garbage otherwise
  always @(posedge sys_clk)
  begin
    xRamRdata <= xRamRd ? mem[xRamAddr] : ~xRamRdata;
    yRamRdata <= yRamRd ? mem[yRamAddr] : ~yRamRdata;
    progRdata <= progRd ? {8'hC3, progAddr[15:0] ^ 16'h3C00} : ~progRdata;
  end
endmodule

// ### dv/dsa_top_tb.sv
// Self-checking testbench for the data-space access unit
`timescale 1ns/10ps
module dsa_top_tb
  import dsa_pkg::*;
;
  logic        sys_clk, reset_n, programSpaceViewEnable;
  logic [7:0]  programViewPage;
  logic        reqValid, reqWrite, reqByte, reqMac, reqAccWriteback, reqTable;
  dsa_class_t  reqClass;
  logic [15:0] reqAddr, reqWdata, reqYAddr;
  logic [3:0]  reqXPtr, reqYPtr;
  logic        inLoop, loopFirst, loopLast, loopIntExit, loopReentry;
  logic        ptrValid, ptrByte, ptrModEnable, ptrBitRevEnable, ptrXWrite;
  logic [15:0] ptrIn, ptrModStart, ptrModEnd, ptrBitRevStep;
  logic        reqReady, rspValid, addrErrTrap, xRamRd, xRamWr, yRamRd, progRd, ptrOutValid;
  logic [15:0] rspXData, rspYData, xRamWdata, xRamRdata, yRamRdata, ptrOut;
  logic [14:0] xRamAddr, yRamAddr, sxa;
  logic [1:0]  xRamBe, sbe;
  logic [22:0] progAddr, spa;
  logic [23:0] progRdata;
  logic        sxr, sxw, syr, spr;
  int          mismatches, checksDone, lat;

  dsa_top DUT (.sys_clk, .reset_n, .programSpaceViewEnable, .programViewPage, .reqValid,
    .reqReady, .reqWrite, .reqByte, .reqMac, .reqAccWriteback, .reqTable, .reqClass,
    .reqAddr, .reqWdata, .reqXPtr, .reqYAddr, .reqYPtr, .inLoop, .loopFirst, .loopLast,
    .loopIntExit, .loopReentry, .rspValid, .rspXData, .rspYData, .addrErrTrap, .xRamAddr,
    .xRamRd, .xRamWr, .xRamBe, .xRamWdata, .xRamRdata, .yRamAddr, .yRamRd, .yRamRdata,
    .progAddr, .progRd, .progRdata, .ptrValid, .ptrIn, .ptrByte, .ptrModEnable,
    .ptrModStart, .ptrModEnd, .ptrBitRevEnable, .ptrBitRevStep, .ptrXWrite, .ptrOutValid,
    .ptrOut);

  dsa_mem_model MEM (.sys_clk, .xRamAddr, .xRamRd, .xRamWr, .xRamBe, .xRamWdata,
    .xRamRdata, .yRamAddr, .yRamRd, .yRamRdata, .progAddr, .progRd, .progRdata);

  always #4 sys_clk = ~sys_clk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One request, taken at the next edge, watched until its response
  task automatic go(input logic [15:0] a, input logic w, input logic b, input logic [15:0] wd);
    reqAddr = a;
    reqWrite = w;
    reqByte = b;
    reqWdata = wd;
    reqValid = 1'b1;
    @(posedge sys_clk);
    #1;
    reqValid = 1'b0;
    {sxr, sxw, syr, spr, sbe, sxa, spa} = '0;
    lat = 0;
    while (rspValid !== 1'b1 && lat < 12)
    begin
      sxr |= (xRamRd === 1'b1);
      sxw |= (xRamWr === 1'b1);
      syr |= (yRamRd === 1'b1);
      spr |= (progRd === 1'b1);
      if (xRamWr === 1'b1)
        sbe = xRamBe;
      if (xRamRd === 1'b1 || xRamWr === 1'b1)
        sxa = xRamAddr;
      if (progRd === 1'b1)
        spa = progAddr;
      @(posedge sys_clk);
      #1;
      lat++;
    end
    {reqMac, reqAccWriteback, reqTable, inLoop, loopFirst, loopLast, loopIntExit} = '0;
    loopReentry = 1'b0;
    reqClass = CLS_MOVE;
    if (rspValid !== 1'b1)
    begin
      mismatches++;
      $display("unexpected rspValid: expected 1 seen %b", rspValid);
      results();
    end
  endtask

  task automatic t_lanes();
    go(16'h0802, 1'b1, 1'b0, 16'h1234);
    chk("word strobe", 3'b111, {sxw, sbe});
    chk("word index", 15'h0401, sxa);
    go(16'h0802, 1'b0, 1'b0, 16'h0000);
    chk("word read", 16'h1234, rspXData);
    chk("read latency", 2, lat);
    go(16'h0805, 1'b1, 1'b1, 16'h00CC);
    chk("byte lanes", 2'b10, sbe);
    chk("byte data", 16'hCCCC, xRamWdata);
    go(16'h0804, 1'b0, 1'b0, 16'h0000);
    chk("other lane kept", 16'hCC02, rspXData);
    go(16'h0805, 1'b0, 1'b1, 16'h0000);
    chk("odd byte read", 16'h00CC, rspXData);
    go(16'h0804, 1'b0, 1'b1, 16'h0000);
    chk("even byte read", 16'h0002, rspXData);
    $display("lane test done");
  endtask

  task automatic t_invalid();
    go(16'h0400, 1'b0, 1'b0, 16'h0000);
    chk("unimplemented data", 16'h0000, rspXData);
    chk("unimplemented strobe", 0, sxr);
    go(16'h8000, 1'b0, 1'b0, 16'h0000);
    chk("view off program read", 0, spr);
    chk("view off data", 16'h0000, rspXData);
    $display("invalid test done");
  endtask

  task automatic t_view();
    programSpaceViewEnable = 1'b1;
    programViewPage = 8'h5A;
    for (int i = 0; i < 4; i++)
    begin
      reqClass = dsa_class_t'(2'(i));
      go(16'h8006 + 16'(2 * i), 1'b0, 1'b0, 16'h0000);
      chk("view latency", (i == 3) ? 4 : 3, lat);
      chk("view address", {8'h5A, 15'h0006 + 15'(2 * i)}, spa);
      chk("view data", 16'h3C06 + 16'(2 * i), rspXData);
    end
    for (int i = 0; i < 5; i++)
    begin
      inLoop = 1'b1;
      {loopFirst, loopLast, loopIntExit, loopReentry} = (i == 0) ? 4'h0 : 4'(8 >> (i - 1));
      go(16'h8010, 1'b0, 1'b0, 16'h0000);
      chk("loop latency", (i == 0) ? 2 : 4, lat);
    end
    reqTable = 1'b1;
    go(16'h8000, 1'b0, 1'b0, 16'h0000);
    chk("table program read", 0, spr);
    chk("table data", 16'h0000, rspXData);
    programSpaceViewEnable = 1'b0;
    $display("view test done");
  endtask

  task automatic t_misalign();
    go(16'h0809, 1'b0, 1'b0, 16'h0000);
    chk("read trap", 1, addrErrTrap);
    chk("read completes", 16'hA104, rspXData);
    go(16'h0807, 1'b1, 1'b0, 16'hBEEF);
    chk("write trap", 1, addrErrTrap);
    chk("write suppressed", 0, sxw);
    go(16'h0806, 1'b0, 1'b0, 16'h0000);
    chk("memory unchanged", 16'hA103, rspXData);
    chk("aligned no trap", 0, addrErrTrap);
    $display("misalign test done");
  endtask

  // Dual prefetch with pointer number, X address and Y address
  task automatic mac(input logic [3:0] xp, input logic [3:0] yp, input logic [15:0] xa,
    input logic [15:0] ya);
    reqMac = 1'b1;
    reqXPtr = xp;
    reqYPtr = yp;
    reqYAddr = ya;
    go(xa, 1'b0, 1'b0, 16'h0000);
  endtask

  task automatic t_mac();
    mac(DSA_X_PTR_A, DSA_Y_PTR_B, 16'h0810, 16'h0C10);
    chk("x operand", 16'hA108, rspXData);
    chk("y operand", 16'hA308, rspYData);
    chk("y path used", 1, syr);
    chk("y index", 15'h0608, yRamAddr);
    mac(DSA_Y_PTR_A, DSA_X_PTR_B, 16'h0810, 16'h0C10);
    chk("crossed x", 16'h0000, rspXData);
    chk("crossed y", 16'h0000, rspYData);
    mac(DSA_X_PTR_B, DSA_Y_PTR_A, 16'h0C20, 16'h0812);
    chk("x into y space", 16'h0000, rspXData);
    chk("y into x space", 16'h0000, rspYData);
    reqAccWriteback = 1'b1;
    go(16'h0C04, 1'b0, 1'b0, 16'h7E57);
    chk("writeback on x bus", 1, sxw);
    chk("writeback index", 15'h0602, sxa);
    go(16'h0C04, 1'b0, 1'b0, 16'h0000);
    chk("writeback data", 16'h7E57, rspXData);
    $display("prefetch test done");
  endtask

  task automatic pstep(input logic [15:0] p, input logic [4:0] md, input logic [15:0] e);
    ptrIn = p;
    {ptrByte, ptrModEnable, ptrBitRevEnable, ptrXWrite} = md[3:0];
    ptrModStart = {p[15:8], 8'h00};
    ptrModEnd = {p[15:8], 8'h1E};
    ptrBitRevStep = 16'h0008;
    ptrValid = 1'b1;
    @(posedge sys_clk);
    #1;
    chk("pointer valid", 1, ptrOutValid);
    chk("pointer next", e, ptrOut);
  endtask

  task automatic t_ptr();
    pstep(16'h0900, 5'h08, 16'h0901);
    pstep(16'h0900, 5'h00, 16'h0902);
    pstep(16'h0A1E, 5'h04, 16'h0A00);
    pstep(16'h0C1E, 5'h04, 16'h0C00);
    pstep(16'h0008, 5'h03, 16'h0004);
    pstep(16'h0008, 5'h02, 16'h000A);
    ptrValid = 1'b0;
    $display("pointer test done");
  endtask

  initial
  begin
    {sys_clk, reset_n, programSpaceViewEnable, programViewPage, reqValid, reqWrite} = '0;
    {reqByte, reqMac, reqAccWriteback, reqTable, reqAddr, reqWdata, reqYAddr} = '0;
    {reqXPtr, reqYPtr, inLoop, loopFirst, loopLast, loopIntExit, loopReentry} = '0;
    {ptrValid, ptrByte, ptrModEnable, ptrBitRevEnable, ptrXWrite, ptrIn} = '0;
    {ptrModStart, ptrModEnd, ptrBitRevStep} = '0;
    reqClass = CLS_MOVE;
    mismatches = 0;
    checksDone = 0;
    repeat (4) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    chk("ready after reset", 1, reqReady);
    chk("quiet after reset", 0, {rspValid, addrErrTrap, xRamWr});
    t_lanes();
    t_invalid();
    t_view();
    t_misalign();
    t_mac();
    t_ptr();
    results();
  end
endmodule
